// file: hw/flash_iap_page_programmer.v
// in-application flash programming: address, data and control registers, page buffer,
// erase / page write / word read sequencing toward the flash array.
// assumes a single-cycle 8-bit register port and a flash array with a request/done handshake.
// Notes on behaviour
// R1: erase and write act on whole pages, read on one word
// R2: page and write buffer both hold 32 words
// R3: software erases a page before writing it
// R4: enabled flag goes high when the enable procedure succeeds
// R5: buffer accepts data only while the enabled flag is high
// R6: write initiate stays high during a write, cleared when done
// R7: read needs read enable; read initiate starts a word read
// R8: read initiate clears at read completion, acting as busy
// R9: erase selects page from address bits above bit 4
// R10: clear-buffer bit empties the buffer then falls low
// R11: software clears the buffer before first use and on updates
// R12: buffer maps onto page chosen by address bits 5 upward
// R13: word0 high write loads high and low bytes into buffer
// R14: each buffer load below the last word of the page increments address and writes it back
// R15: address stops at last word of page, no wrap
// R16: buffer clears automatically when a page write ends
// R17: software clears and reloads buffer after failed verify
// R18: low address and data in sector 0; rest in sector 1
// R19: high address holds 4 bits; upper bits read zero
// R20: 3-bit mode field: write, erase, read, enable; others reserved
// R21: trigger bit starts timer, cleared by hardware at expiry
// R22: software may clear enabled flag; writing one does nothing
// R23: word0 low write only updates that register
// R24: busy initiate bits stay high and ignore new requests
`timescale 1ns/1ps
`include "flash_iap_map.vh"

module flash_iap_page_programmer #(
  parameter TRIGGER_COUNT = `TRIGGER_CYCLES,
  parameter [15:0] PATTERN1 = 16'h0000,
  parameter [15:0] PATTERN2 = 16'h0000,
  parameter [15:0] PATTERN3 = 16'h0000
) (
  input  wire        core_clk,
  input  wire        reset_n,
  input  wire        regSector,
  input  wire [3:0]  regAddr,
  input  wire        regWrite,
  input  wire [7:0]  regWdata,
  output reg  [7:0]  regRdata,
  output reg         flashEraseReq,
  output reg         flashWriteReq,
  output reg         flashReadReq,
  output reg  [11:0] flashAddr,
  output wire [511:0] flashWdata,
  input  wire        flashDone,
  input  wire [15:0] flashRdata,
  output wire        cpuStall
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_ERASE = 2'h1;
  localparam ST_WRITE = 2'h2;
  localparam ST_READ  = 2'h3;

  reg [7:0]  addrLow_reg;
  reg [3:0]  addrHigh_reg;
  reg [7:0]  dataLow_reg  [0:3];
  reg [7:0]  dataHigh_reg [0:3];
  reg        enFlag_reg;
  reg [2:0]  mode_reg;
  reg        trigger_reg;
  reg        writeInit_reg;
  reg        readEn_reg;
  reg        readInit_reg;
  reg        clrBuf_reg;
  reg        clrD7_reg;
  reg        clrD4_reg;
  reg [1:0]  state_reg;
  reg [17:0] timer_reg;
  reg [15:0] buffer_reg [0:31];
  integer    i;

  function isWr;
    input       sec;
    input [3:0] ofs;
    input       s;
    input [3:0] o;
    isWr = regWrite && (sec == s) && (ofs == o);
  endfunction

  wire [11:0] curAddr   = {addrHigh_reg, addrLow_reg};
  wire [2:0]  newMode   = regWdata[`MODE_MSB:`MODE_LSB];
  wire        wrCtrl    = isWr(regSector, regAddr, 1'b1, `OP_CTRL_OFS);
  wire        wrClr     = isWr(regSector, regAddr, 1'b1, `BUF_CLR_CTRL_OFS);
  wire        wrHigh0   = isWr(regSector, regAddr, 1'b1, `WORD0_HIGH_OFS);
  wire        busy      = (state_reg != ST_IDLE) || clrBuf_reg;
  wire        atPageEnd = (addrLow_reg[`OFFSET_BITS-1:0] == 5'h1F);
  // a word load is refused while disabled or while an operation runs
  wire        loadWord  = wrHigh0 && enFlag_reg && !busy;
  wire        readDone  = (state_reg == ST_READ) && flashDone;
  wire        writeDone = (state_reg == ST_WRITE) && flashDone;
  // mode travels in the same write as the initiate bit, as for the trigger
  wire startWrite = wrCtrl && !busy && regWdata[`WRITE_INIT_BIT] && enFlag_reg
                    && (newMode == `MODE_WRITE);
  wire startErase = wrCtrl && !busy && regWdata[`WRITE_INIT_BIT] && enFlag_reg
                    && (newMode == `MODE_ERASE);
  wire startRead  = wrCtrl && !busy && regWdata[`READ_INIT_BIT] && readEn_reg
                    && !regWdata[`WRITE_INIT_BIT] && (newMode == `MODE_READ);
  wire startTrig  = wrCtrl && !busy && regWdata[`TRIGGER_BIT] && !trigger_reg
                    && (newMode == `MODE_ENABLE);
  // enable procedure passes when the three pattern pairs match at timeout
  wire patternOk = {dataHigh_reg[1], dataLow_reg[1]} == PATTERN1 &&
                   {dataHigh_reg[2], dataLow_reg[2]} == PATTERN2 &&
                   {dataHigh_reg[3], dataLow_reg[3]} == PATTERN3;
  wire timerDone = trigger_reg && (timer_reg == TRIGGER_COUNT - 1);

  assign cpuStall = (state_reg != ST_IDLE);

  // address pair; the load bump never leaves the current page
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      addrLow_reg  <= `BYTE_RESET;
      addrHigh_reg <= `HIGH_RESET;
    end else begin
      if (regWrite && !regSector && (regAddr == `ADDR_LOW_OFS)) begin // R18
        addrLow_reg <= regWdata;
      end
      if (regWrite && regSector && (regAddr == `ADDR_HIGH_OFS)) begin
        addrHigh_reg <= regWdata[3:0]; // R19
      end
      // software must pick a new page once the last word is loaded
      if (loadWord && !atPageEnd) begin // R15
        addrLow_reg <= curAddr[7:0] + 8'h01; // R14
      end
    end
  end

  // data words; word0 also receives the result of a word read
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (i = 0; i < 4; i = i + 1) begin
        dataLow_reg[i]  <= `BYTE_RESET;
        dataHigh_reg[i] <= `BYTE_RESET;
      end
    end else begin
      if (regWrite && !regSector) begin
        case (regAddr)
          `WORD0_LOW_OFS: dataLow_reg[0] <= regWdata; // R23
          `WORD1_LOW_OFS: dataLow_reg[1] <= regWdata;
          `WORD2_LOW_OFS: dataLow_reg[2] <= regWdata;
          `WORD3_LOW_OFS: dataLow_reg[3] <= regWdata;
          default: ;
        endcase
      end
      if (regWrite && regSector) begin
        case (regAddr)
          `WORD0_HIGH_OFS: dataHigh_reg[0] <= regWdata;
          `WORD1_HIGH_OFS: dataHigh_reg[1] <= regWdata;
          `WORD2_HIGH_OFS: dataHigh_reg[2] <= regWdata;
          `WORD3_HIGH_OFS: dataHigh_reg[3] <= regWdata;
          default: ;
        endcase
      end
      if (readDone) begin
        dataLow_reg[0]  <= flashRdata[7:0]; // R8
        dataHigh_reg[0] <= flashRdata[15:8];
      end
    end
  end

  // enable procedure; the timer only runs while the trigger bit is up
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      trigger_reg <= 1'b0;
      timer_reg   <= 18'h00000;
      enFlag_reg  <= 1'b0;
    end else begin
      // a software clear loses to a set at expiry in the same cycle
      if (wrCtrl && !regWdata[`EN_FLAG_BIT]) begin
        enFlag_reg <= 1'b0; // R22
      end
      if (startTrig) begin
        trigger_reg <= 1'b1; // R21
        timer_reg   <= 18'h00000;
      end else if (trigger_reg) begin
        timer_reg <= timer_reg + 18'h00001;
        if (timerDone) begin
          trigger_reg <= 1'b0; // R21
          if (patternOk) begin
            enFlag_reg <= 1'b1; // R4
          end
        end
      end
    end
  end

  // control fields; mode and read enable are frozen while busy
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_reg   <= 3'h0;
      readEn_reg <= 1'b0;
      clrBuf_reg <= 1'b0;
      clrD7_reg  <= 1'b0;
      clrD4_reg  <= 1'b0;
    end else begin
      if (wrCtrl && !busy) begin // R24
        mode_reg   <= newMode; // R20
        readEn_reg <= regWdata[`READ_EN_BIT]; // R7
      end
      if (wrClr) begin
        clrD7_reg <= regWdata[`CLR_D7_BIT];
        clrD4_reg <= regWdata[`CLR_D4_BIT];
      end
      // buffer clear takes one cycle
      if (clrBuf_reg) begin
        clrBuf_reg <= 1'b0; // R10
      end else if (wrClr && regWdata[`CLR_BUF_BIT] && (state_reg == ST_IDLE)) begin
        clrBuf_reg <= 1'b1;
      end
    end
  end

  // operation sequencing toward the array
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      writeInit_reg <= 1'b0;
      readInit_reg  <= 1'b0;
      state_reg     <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (startWrite) begin
            writeInit_reg <= 1'b1; // R6
            state_reg     <= ST_WRITE;
          end else if (startErase) begin
            writeInit_reg <= 1'b1;
            state_reg     <= ST_ERASE;
          end else if (startRead) begin
            readInit_reg <= 1'b1; // R7
            state_reg    <= ST_READ;
          end
        end
        ST_ERASE, ST_WRITE: begin
          if (flashDone) begin
            writeInit_reg <= 1'b0; // R6
            state_reg     <= ST_IDLE;
          end
        end
        ST_READ: begin
          if (readDone) begin
            readInit_reg <= 1'b0; // R8
            state_reg    <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // page buffer, one slot per word of the page
  genvar g;
  generate
    for (g = 0; g < `PAGE_WORDS; g = g + 1) begin : slot // R2
      always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          buffer_reg[g] <= 16'h0000;
        end else if (clrBuf_reg || writeDone) begin
          buffer_reg[g] <= 16'h0000; // R16
        end else if (loadWord && (addrLow_reg[`OFFSET_BITS-1:0] == g)) begin // R5
          buffer_reg[g] <= {regWdata, dataLow_reg[0]}; // R13
        end
      end
      assign flashWdata[g*16 +: 16] = buffer_reg[g];
    end
  endgenerate

  // flash requests and address toward the array
  always @* begin
    flashEraseReq = (state_reg == ST_ERASE); // R1
    flashWriteReq = (state_reg == ST_WRITE);
    flashReadReq  = (state_reg == ST_READ);
    if (state_reg == ST_READ) flashAddr = curAddr;
    else flashAddr = {curAddr[11:5], 5'h00}; // R9 R12
  end

  // read-back mux, one cycle combinational
  always @* begin
    regRdata = 8'h00;
    if (!regSector) begin
      case (regAddr)
        `ADDR_LOW_OFS:  regRdata = addrLow_reg;
        `WORD0_LOW_OFS: regRdata = dataLow_reg[0];
        `WORD1_LOW_OFS: regRdata = dataLow_reg[1];
        `WORD2_LOW_OFS: regRdata = dataLow_reg[2];
        `WORD3_LOW_OFS: regRdata = dataLow_reg[3];
        default:        regRdata = 8'h00;
      endcase
    end else begin
      case (regAddr)
        `ADDR_HIGH_OFS:  regRdata = {4'h0, addrHigh_reg}; // R19
        `WORD0_HIGH_OFS: regRdata = dataHigh_reg[0];
        `WORD1_HIGH_OFS: regRdata = dataHigh_reg[1];
        `WORD2_HIGH_OFS: regRdata = dataHigh_reg[2];
        `WORD3_HIGH_OFS: regRdata = dataHigh_reg[3];
        `OP_CTRL_OFS:    regRdata = {enFlag_reg, mode_reg, trigger_reg,
                                     writeInit_reg, readEn_reg, readInit_reg};
        `BUF_CLR_CTRL_OFS: regRdata = {clrD7_reg, 1'b0, 1'b0, clrD4_reg,
                                       3'h0, clrBuf_reg};
        default:         regRdata = 8'h00;
      endcase
    end
  end
endmodule

// file: hw/flash_iap_map.vh
// register offsets, field positions, reset values and timing for the flash programming block
// assumes an 8-bit special-register port with separate sector-0 and sector-1 address spaces
`ifndef FLASH_IAP_MAP_VH
`define FLASH_IAP_MAP_VH
// sector 0 offsets
`define ADDR_LOW_OFS      4'h0
`define WORD0_LOW_OFS     4'h1
`define WORD1_LOW_OFS     4'h2
`define WORD2_LOW_OFS     4'h3
`define WORD3_LOW_OFS     4'h4
// sector 1 offsets
`define ADDR_HIGH_OFS     4'h0
`define WORD0_HIGH_OFS    4'h1
`define WORD1_HIGH_OFS    4'h2
`define WORD2_HIGH_OFS    4'h3
`define WORD3_HIGH_OFS    4'h4
`define OP_CTRL_OFS       4'h5
`define BUF_CLR_CTRL_OFS  4'h6
// op control fields
`define EN_FLAG_BIT       7
`define MODE_MSB          6
`define MODE_LSB          4
`define TRIGGER_BIT       3
`define WRITE_INIT_BIT    2
`define READ_EN_BIT       1
`define READ_INIT_BIT     0
// buffer clear control fields
`define CLR_D7_BIT        7
`define CLR_D6_BIT        6
`define CLR_D4_BIT        4
`define CLR_BUF_BIT       0
// mode codes
`define MODE_WRITE        3'h0
`define MODE_ERASE        3'h1
`define MODE_READ         3'h3
`define MODE_ENABLE       3'h6
// reset values
`define BYTE_RESET        8'h00
`define HIGH_RESET        4'h0
// geometry
`define PAGE_WORDS        32
`define OFFSET_BITS       5
`define ADDR_BITS         12
// enable procedure timer
`define TRIGGER_TIME_NS   1000000
`define CLK_PERIOD_NS     8
`define TRIGGER_CYCLES    (`TRIGGER_TIME_NS / `CLK_PERIOD_NS)
`endif

// file: bench/flash_iap_monitor.sv
// port checker for the flash programming block
// assumes it is bound onto flash_iap_page_programmer
`timescale 1ns/1ps
module flash_iap_monitor (
  input wire        core_clk,
  input wire        reset_n,
  input wire        regSector,
  input wire [3:0]  regAddr,
  input wire        regWrite,
  input wire [7:0]  regWdata,
  input wire        flashEraseReq,
  input wire        flashWriteReq,
  input wire        flashReadReq,
  input wire [11:0] flashAddr,
  input wire        flashDone,
  input wire        cpuStall
);
  wire ctrlWr = regWrite && regSector && regAddr == 4'h5;
  wire busy = flashEraseReq | flashWriteReq | flashReadReq;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_rise(x);
    !x ##1 x;
  endsequence
  sequence s_end;
    busy && flashDone;
  endsequence
  a_write_start: assert property (s_rise(flashWriteReq) |->
    $past(ctrlWr && regWdata[6:4] == 3'h0 && regWdata[2])) else $error("bad write start");
  a_erase_start: assert property (s_rise(flashEraseReq) |->
    $past(ctrlWr && regWdata[6:4] == 3'h1 && regWdata[2])) else $error("bad erase start");
  a_read_start: assert property (s_rise(flashReadReq) |->
    $past(ctrlWr && regWdata[6:4] == 3'h3 && regWdata[0])) else $error("bad read start");
  a_done_ends: assert property (s_end |=> !busy) else $error("op outlives done");
  a_op_holds: assert property (busy && !flashDone |=> busy) else $error("op dropped");
  a_single_op: assert property ($onehot0({flashEraseReq, flashWriteReq, flashReadReq}))
    else $error("two ops at once");
  a_stall_busy: assert property (cpuStall == busy) else $error("stall mismatch");
  a_page_base: assert property (flashEraseReq || flashWriteReq |-> flashAddr[4:0] == 5'h00)
    else $error("page address not aligned");
endmodule
bind flash_iap_page_programmer flash_iap_monitor flash_iap_monitor_inst (
  .core_clk(core_clk), .reset_n(reset_n), .regSector(regSector), .regAddr(regAddr),
  .regWrite(regWrite), .regWdata(regWdata), .flashEraseReq(flashEraseReq),
  .flashWriteReq(flashWriteReq), .flashReadReq(flashReadReq), .flashAddr(flashAddr),
  .flashDone(flashDone), .cpuStall(cpuStall));

// file: bench/flash_array_model.sv
// flash array model answering each request after a fixed delay
// assumes requests stay high until the done pulse is taken
`timescale 1ns/1ps
module flash_array_model #(
  parameter DELAY = 5
) (
  input  wire        core_clk,
  input  wire        reset_n,
  input  wire        flashEraseReq,
  input  wire        flashWriteReq,
  input  wire        flashReadReq,
  input  wire [11:0] flashAddr,
  output reg         flashDone,
  output reg  [15:0] flashRdata
);
  reg  [3:0] cnt_reg;
  wire       busy = flashEraseReq | flashWriteReq | flashReadReq;
  wire       last = busy && cnt_reg == DELAY - 1;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg    <= 4'h0;
      flashDone  <= 1'b0;
      flashRdata <= 16'h0000;
    end else begin
      flashDone  <= last;
      cnt_reg    <= (busy && !flashDone && !last) ? cnt_reg + 4'h1 : 4'h0;
      // toggles outside the done cycle so a stale sample shows
      flashRdata <= (flashReadReq && last) ? {4'hC, flashAddr} : ~flashRdata;
    end
  end
endmodule

// file: bench/tb.sv
// self-checking bench for the flash programming block
// assumes the array model answers every request after five cycles
`timescale 1ns/1ps
module tb;
  reg         core_clk = 1'b0;
  reg         reset_n = 1'b0;
  reg         regSector = 1'b0;
  reg  [3:0]  regAddr = 4'h0;
  reg         regWrite = 1'b0;
  reg  [7:0]  regWdata = 8'h00;
  wire [7:0]  regRdata;
  wire        eReq, wReq, rReq, flashDone, cpuStall;
  wire [11:0] flashAddr;
  wire [15:0] flashRdata;
  wire [511:0] flashWdata;
  integer     errors = 0;
  integer     comparisons = 0;
  integer     i;
  initial forever #4 core_clk = ~core_clk;
  // short enable timer keeps the run brief; the pattern value is arbitrary
  flash_iap_page_programmer #(.TRIGGER_COUNT(20), .PATTERN1(16'hA55A))
    flash_iap_page_programmer_inst (
    .core_clk(core_clk), .reset_n(reset_n), .regSector(regSector), .regAddr(regAddr),
    .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata), .flashEraseReq(eReq),
    .flashWriteReq(wReq), .flashReadReq(rReq), .flashAddr(flashAddr),
    .flashWdata(flashWdata), .flashDone(flashDone), .flashRdata(flashRdata),
    .cpuStall(cpuStall));
  flash_array_model flash_array_model_inst (.core_clk(core_clk), .reset_n(reset_n),
    .flashEraseReq(eReq), .flashWriteReq(wReq), .flashReadReq(rReq),
    .flashAddr(flashAddr), .flashDone(flashDone), .flashRdata(flashRdata));
  task check(input string n, input [15:0] e, input [15:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task wr(input s, input [3:0] a, input [7:0] d);
    begin
      @(posedge core_clk);
      regSector <= s;
      regAddr   <= a;
      regWdata  <= d;
      regWrite  <= 1'b1;
      @(posedge core_clk);
      regWrite  <= 1'b0;
      @(negedge core_clk);
    end
  endtask
  task rd(input string n, input s, input [3:0] a, input [7:0] e);
    begin
      @(posedge core_clk);
      regSector <= s;
      regAddr   <= a;
      @(negedge core_clk);
      check(n, {8'h00, e}, {8'h00, regRdata});
    end
  endtask
  task wait_idle;
    begin
      for (i = 0; i < 50 && cpuStall !== 1'b0; i = i + 1) @(negedge core_clk);
      check("cpuStall", 16'h0000, {15'h0000, cpuStall});
    end
  endtask
  task t_reset;
    begin
      rd("ctrl", 1, 4'h5, 8'h00);
      wr(1, 4'h0, 8'hFF);
      rd("addrHigh", 1, 4'h0, 8'h0F);
      wr(1, 4'h5, 8'h80);
      rd("ctrl", 1, 4'h5, 8'h00);
      wr(0, 4'h1, 8'h34);
      wr(1, 4'h1, 8'h12);
      check("buf0", 16'h0000, flashWdata[15:0]);
      rd("addrLow", 0, 4'h0, 8'h00);
    end
  endtask
  task t_enable;
    begin
      wr(1, 4'h5, 8'h68);
      repeat (22) @(posedge core_clk);
      rd("ctrl", 1, 4'h5, 8'h60);
      wr(0, 4'h2, 8'h5A);
      wr(1, 4'h2, 8'hA5);
      wr(1, 4'h5, 8'h68);
      repeat (15) @(posedge core_clk);
      rd("ctrl", 1, 4'h5, 8'h68);
      repeat (5) @(posedge core_clk);
      rd("ctrl", 1, 4'h5, 8'hE0);
    end
  endtask
  task t_erase;
    begin
      wr(0, 4'h0, 8'hA7);
      wr(1, 4'h0, 8'h03);
      wr(1, 4'h5, 8'h94);
      check("eraseAddr", 16'h13A0, {3'h0, eReq, flashAddr});
      wait_idle;
      rd("ctrl", 1, 4'h5, 8'h90);
    end
  endtask
  task t_fill;
    begin
      wr(1, 4'h6, 8'h01);
      rd("bufClr", 1, 4'h6, 8'h00);
      wr(0, 4'h0, 8'hBE);
      wr(0, 4'h1, 8'h34);
      wr(1, 4'h1, 8'h12);
      check("buf30", 16'h1234, flashWdata[495:480]);
      rd("addrLow", 0, 4'h0, 8'hBF);
      wr(0, 4'h1, 8'h56);
      check("buf31", 16'h0000, flashWdata[511:496]);
      wr(1, 4'h1, 8'h78);
      check("buf31", 16'h7856, flashWdata[511:496]);
      rd("addrLow", 0, 4'h0, 8'hBF);
    end
  endtask
  task t_write;
    begin
      wr(1, 4'h5, 8'h84);
      check("writeAddr", 16'h13A0, {3'h0, wReq, flashAddr});
      rd("ctrl", 1, 4'h5, 8'h84);
      wait_idle;
      rd("ctrl", 1, 4'h5, 8'h80);
      check("buf31", 16'h0000, flashWdata[511:496]);
      wr(0, 4'h1, 8'hCD);
      wr(1, 4'h1, 8'hAB);
      check("buf31", 16'hABCD, flashWdata[511:496]);
      wr(1, 4'h6, 8'h01);
      check("bufClrBit", 16'h0001, {8'h00, regRdata});
      @(negedge core_clk);
      check("buf31", 16'h0000, flashWdata[511:496]);
    end
  endtask
  task t_read;
    begin
      wr(0, 4'h0, 8'h45);
      wr(1, 4'h5, 8'hB2);
      wr(1, 4'h5, 8'hB3);
      check("readAddr", 16'h1345, {3'h0, rReq, flashAddr});
      wait_idle;
      rd("ctrl", 1, 4'h5, 8'hB2);
      rd("word0High", 1, 4'h1, 8'hC3);
      rd("word0Low", 0, 4'h1, 8'h45);
      wr(1, 4'h5, 8'h00);
      rd("ctrl", 1, 4'h5, 8'h00);
    end
  endtask
  task give_verdict;
    begin
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #20000;
    errors = errors + 1;
    give_verdict;
  end
  initial begin
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset;
    t_enable;
    t_erase;
    t_fill;
    t_write;
    t_read;
    give_verdict;
  end
endmodule
